//--- packet_test_fifo_status_tb.sv
// Self-checking bench for the test packet and FIFO status registers
`timescale 1ns/1ps
module packet_test_fifo_status_tb;
   logic i_clk_sys = 0, i_rst = 1, i_sw_rst = 0, i_wr = 0, i_rd = 0;
   logic i_phx_empty = 0, i_phx_full = 0, i_phr_full = 0, i_phr_empty = 0;
   logic i_crc_err = 0, i_rfifo_ovf = 0, i_rfifo_udf = 0;
   logic [2:0] i_coding_mode = 3'h1;
   logic [15:0] i_addr = 16'h0000, i_wdata = 16'h0000, o_rdata, o_gen_count;
   logic [239:0] i_cnt_vals;
   logic [4:0] o_cnt_rd_clr;
   logic [1:0] o_rfifo_depth;
   logic [3:0] o_pattern;
   logic [31:0] o_seed;
   logic o_irq, o_read_clr_en, o_cnt_clear, o_chk_skip8, o_gen_en, o_chk_en;
   logic o_gen_run, o_gen_continuous, o_crc_append;
   wire [3:0] ctrl_o = {o_read_clr_en, o_chk_skip8, o_gen_en, o_chk_en};
   logic [15:0] ra [9] = '{16'hf008, 16'hf00a, 16'hf00b, 16'hf00c, 16'hf010,
      16'hf011, 16'hf012, 16'hf013, 16'hf009};
   logic [6:0] pev [4] = '{7'h40, 7'h20, 7'h10, 7'h08};
   logic [15:0] pex [4] = '{16'h0004, 16'h0004, 16'h0002, 16'h0001};
   int fails = 0, total_checks = 0;
   always #12.5 i_clk_sys = ~i_clk_sys;
   ptfs_regs DUT (.i_clk_sys, .i_rst, .i_sw_rst, .i_coding_mode, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata, .i_phx_empty, .i_phx_full,
      .i_phr_full, .i_phr_empty, .i_crc_err, .i_rfifo_ovf, .i_rfifo_udf,
      .i_cnt_vals, .o_irq, .o_rfifo_depth, .o_read_clr_en, .o_cnt_clear,
      .o_cnt_rd_clr, .o_chk_skip8, .o_gen_en, .o_chk_en, .o_gen_run,
      .o_gen_continuous, .o_gen_count, .o_pattern, .o_crc_append, .o_seed);
   ptfs_cnt_model u_cnt (.i_clk_sys, .i_rst, .i_cnt_clear(o_cnt_clear),
      .i_rd_clr(o_cnt_rd_clr), .o_cnt_vals(i_cnt_vals));
   task automatic chk(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, d);
      @(posedge i_clk_sys);
      i_wr <= 1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 0;
   endtask
   task automatic rd_reg(input logic [15:0] a, e, m = 16'hffff);
      @(posedge i_clk_sys);
      i_rd <= 1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 0;
      #1 chk($sformatf("reg %h", a), e, o_rdata & m);
   endtask
   task automatic pulse(input logic [6:0] b);
      @(posedge i_clk_sys);
      {i_phx_empty, i_phx_full, i_phr_full, i_phr_empty} <= b[6:3];
      {i_crc_err, i_rfifo_ovf, i_rfifo_udf} <= b[2:0];
      @(posedge i_clk_sys);
      {i_phx_empty, i_phx_full, i_phr_full, i_phr_empty} <= 4'h0;
      {i_crc_err, i_rfifo_ovf, i_rfifo_udf} <= 3'h0;
   endtask
   // Outputs trail the registers by a cycle
   task automatic settle;
      @(posedge i_clk_sys);
      #1;
   endtask
   task end_of_test;
      if (fails == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (50000) @(posedge i_clk_sys);
      fails++;
      end_of_test();
   end
   initial
   begin
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 0;
      for (int i = 0; i < 9; i++)
         rd_reg(ra[i], i == 3 ? 16'h4000 : 16'h0000);
      chk("crc_append", 1, o_crc_append);
      for (int i = 0; i < 4; i++)
      begin
         pulse(pev[i]);
         rd_reg(16'hf008, pex[i]);
         rd_reg(16'hf008, 16'h0000);
      end
      pulse(7'h04);
      rd_reg(16'hf00b, 16'h0000);
      wr_reg(16'hf010, 16'h0001);
      pulse(7'h04);
      rd_reg(16'hf00b, 16'h0004);
      wr_reg(16'hf00a, 16'h0002);
      rd_reg(16'hf00a, 16'h0002);
      pulse(7'h01);
      settle();
      chk("irq", 0, o_irq);
      rd_reg(16'hf00b, 16'h0001);
      pulse(7'h02);
      settle();
      chk("irq", 1, o_irq);
      rd_reg(16'hf00b, 16'h0002);
      settle();
      chk("irq", 0, o_irq);
      pulse(7'h02);
      rd_reg(16'hf00b, 16'h0002);
      rd_reg(16'hf00b, 16'h0000);
      wr_reg(16'hf010, 16'h8007);
      rd_reg(16'hf010, 16'h8007);
      chk("ctrl", 4'hf, ctrl_o);
      wr_reg(16'hf010, 16'h0002);
      settle();
      chk("ctrl", 4'h2, ctrl_o);
      wr_reg(16'hf017, 16'hffff);
      settle();
      chk("run", 2'h3, {o_gen_run, o_gen_continuous});
      wr_reg(16'hf017, 16'h0005);
      settle();
      chk("run", 2'h2, {o_gen_run, o_gen_continuous});
      chk("count", 16'h0005, o_gen_count);
      wr_reg(16'hf017, 16'h0000);
      settle();
      chk("run", 2'h0, {o_gen_run, o_gen_continuous});
      for (int p = 0; p < 16; p++)
      begin
         wr_reg(16'hf011, {8'h00, 4'(p), 4'h8});
         settle();
         chk("pattern", (p < 2 || p > 11) ? 0 : p, o_pattern);
         chk("crc_append", 0, o_crc_append);
      end
      wr_reg(16'hf011, 16'hffff);
      rd_reg(16'hf011, 16'h00f8);
      wr_reg(16'hf012, 16'h2211);
      wr_reg(16'hf013, 16'h4433);
      settle();
      chk("seed", 32'h44332211, o_seed);
      rd_reg(16'hf01f, 16'h0000);
      rd_reg(16'hf01e, 16'h0000, 16'h0000);
      rd_reg(16'hf01f, 16'h00b1);
      rd_reg(16'hf020, 16'h00a1);
      wr_reg(16'hf010, 16'h8000);
      rd_reg(16'hf021, 16'h0000, 16'h0000);
      rd_reg(16'hf022, 16'h00b2);
      rd_reg(16'hf021, 16'h0000, 16'h0000);
      rd_reg(16'hf023, 16'h0000);
      wr_reg(16'hf010, 16'h0040);
      rd_reg(16'hf010, 16'h0000);
      rd_reg(16'hf01b, 16'h0000, 16'h0000);
      rd_reg(16'hf01c, 16'h0000);
      wr_reg(16'hf00c, 16'h8000);
      rd_reg(16'hf00c, 16'h8000);
      for (int m = 0; m < 8; m++)
      begin
         @(posedge i_clk_sys);
         i_coding_mode <= 3'(m);
         i_sw_rst <= 1;
         @(posedge i_clk_sys);
         i_sw_rst <= 0;
         rd_reg(16'hf00c, (m >= 1 && m <= 3) ? 16'h4000 :
            m == 4 ? 16'hc000 : 16'h0000);
         chk("depth", (m >= 1 && m <= 3) ? 1 : m == 4 ? 3 : 0,
            o_rfifo_depth);
      end
      rd_reg(16'hf01f, 16'h0000);
      rd_reg(16'hf012, 16'h2211);
      end_of_test();
   end
endmodule // packet_test_fifo_status_tb

//--- ptfs_cnt_model.sv
// Counter source standing in for the generator and checker counters
`timescale 1ns/1ps
module ptfs_cnt_model (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_cnt_clear,
   input wire logic [4:0] i_rd_clr,
   output logic [239:0] o_cnt_vals
);
   logic [15:0] lo_q [5];
   logic [31:0] up_q [5];
   // Upper words never count, only load at reset or clear to zero, so a snapshot has a known value
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      for (int k = 0; k < 5; k++)
      begin
         lo_q[k] <= lo_q[k] + 16'h0001;
         if (i_rst || i_cnt_clear || i_rd_clr[k])
         begin
            lo_q[k] <= 16'h0000;
            up_q[k] <= i_rst ? {16'h00a0 + 16'(k), 16'h00b0 + 16'(k)} : 0;
         end
      end
   end
   always_comb
      for (int k = 0; k < 5; k++)
         o_cnt_vals[k*48 +: 48] = {up_q[k], lo_q[k]};
endmodule // ptfs_cnt_model

//--- ptfs_map.vh
// Register map and field constants for the test packet / FIFO status bank
// Function
// - Transmit phase FIFO empty/full latches bit 2
// - Receive phase FIFO full latches bit 1
// - Receive phase FIFO empty latches bit 0
// - Interrupt only for enabled latched events
// - CRC error latched only while checker enabled
// - Rate FIFO overflow latches until read
// - Rate FIFO underflow latches until read
// - Depth field, default follows coding mode
// - Bit 15 makes counter reads clear
// - Bit 6 clears counters, then self-clears
// - Bit 2 selects SFD or 8-byte start
// - Bit 1 enables the packet generator
// - Bit 0 enables the packet checker
// - Pattern codes 0010 to 0111 shape payload; 000x give none
// - Codes 1000 to 1011; 11xx reserved
// - Two registers seed four payload bytes
// - Low word read snapshots upper counter words
// - Packet count 0 stops, FFFF continuous
`ifndef PTFS_MAP_VH
`define PTFS_MAP_VH
`define PTFS_OFS_PHASE 16'hf008
`define PTFS_OFS_IRQ_EN 16'hf00a
`define PTFS_OFS_IRQ_FLG 16'hf00b
`define PTFS_OFS_DEPTH 16'hf00c
`define PTFS_OFS_CTRL_A 16'hf010
`define PTFS_OFS_CTRL_B 16'hf011
`define PTFS_OFS_SEED_LO 16'hf012
`define PTFS_OFS_SEED_HI 16'hf013
`define PTFS_OFS_BURST 16'hf017
`define PTFS_OFS_CNT_BASE 16'hf01b
`define PTFS_CNT_STRIDE 16'h0003
`define PTFS_CNT_MID 16'h0001
`define PTFS_CNT_HI 16'h0002
`define PTFS_B_READ_CLR 15
`define PTFS_B_CNT_RST 6
`define PTFS_B_USE_SFD 2
`define PTFS_B_GEN_EN 1
`define PTFS_B_CHK_EN 0
`define PTFS_B_CRC_OFF 3
`define PTFS_F_PAT_HI 7
`define PTFS_F_PAT_LO 4
`define PTFS_F_DEP_HI 15
`define PTFS_F_DEP_LO 14
`define PTFS_MODE_10GR 3'h1
`define PTFS_MODE_XAUI 3'h2
`define PTFS_MODE_RXAUI 3'h3
`define PTFS_MODE_40GR4 3'h4
`define PTFS_DEP_10G 2'h1
`define PTFS_DEP_40G 2'h3
`define PTFS_DEP_OTHER 2'h0
`define PTFS_PAT_NONE 4'h0
`define PTFS_PAT_RSVD_TOP 2'h3
`define PTFS_BURST_STOP 16'h0000
`define PTFS_BURST_CONT 16'hffff
`define PTFS_RST16 16'h0000
`endif

//--- ptfs_regs.v
// Status, interrupt-enable and test packet control register bank
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "ptfs_map.vh"
module ptfs_regs #(
   parameter N_CNT = 5,
   parameter CNT_W = 48
)
(
   input wire i_clk_sys,
   input wire i_rst,
   input wire i_sw_rst,
   input wire [2:0] i_coding_mode,
   input wire [15:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [15:0] o_rdata,
   input wire i_phx_empty,
   input wire i_phx_full,
   input wire i_phr_full,
   input wire i_phr_empty,
   input wire i_crc_err,
   input wire i_rfifo_ovf,
   input wire i_rfifo_udf,
   input wire [N_CNT*CNT_W-1:0] i_cnt_vals,
   output reg o_irq,
   output reg [1:0] o_rfifo_depth,
   output reg o_read_clr_en,
   output reg o_cnt_clear,
   output reg [N_CNT-1:0] o_cnt_rd_clr,
   output reg o_chk_skip8,
   output reg o_gen_en,
   output reg o_chk_en,
   output reg o_gen_run,
   output reg o_gen_continuous,
   output reg [15:0] o_gen_count,
   output reg [3:0] o_pattern,
   output reg o_crc_append,
   output reg [31:0] o_seed
);

   reg [2:0] phase_q;
   reg [2:0] phase_d;
   reg [2:0] irq_en_q;
   reg [2:0] irq_flg_q;
   reg [2:0] irq_flg_d;
   reg [1:0] depth_q;
   reg depth_loaded_q;
   reg [1:0] mode_depth;
   reg read_clr_q;
   reg cnt_rst_q;
   reg use_sfd_q;
   reg gen_en_q;
   reg chk_en_q;
   reg [3:0] pat_q;
   reg crc_off_q;
   reg [15:0] seed_lo_q;
   reg [15:0] seed_hi_q;
   reg [15:0] burst_q;
   reg [15:0] rdata_d;
   reg [3:0] pat_eff;
   wire [CNT_W-17:0] snap_w [0:N_CNT-1];
   wire [N_CNT-1:0] lo_rd;
   wire [N_CNT-1:0] mid_hit;
   wire [N_CNT-1:0] hi_hit;
   wire [N_CNT-1:0] lo_hit;
   wire rd_phase;
   wire rd_flg;
   wire wr_depth;
   wire wr_irq_en;
   wire wr_ctrl_a;
   wire wr_ctrl_b;
   wire wr_seed_lo;
   wire wr_seed_hi;
   wire wr_burst;
   reg irq_d;

   assign rd_phase = i_rd && (i_addr == `PTFS_OFS_PHASE);
   assign rd_flg = i_rd && (i_addr == `PTFS_OFS_IRQ_FLG);

   // One decode per register keeps the write paths easy to audit
   assign wr_depth = i_wr && (i_addr == `PTFS_OFS_DEPTH);
   assign wr_irq_en = i_wr && (i_addr == `PTFS_OFS_IRQ_EN);
   assign wr_ctrl_a = i_wr && (i_addr == `PTFS_OFS_CTRL_A);
   assign wr_ctrl_b = i_wr && (i_addr == `PTFS_OFS_CTRL_B);
   assign wr_seed_lo = i_wr && (i_addr == `PTFS_OFS_SEED_LO);
   assign wr_seed_hi = i_wr && (i_addr == `PTFS_OFS_SEED_HI);
   assign wr_burst = i_wr && (i_addr == `PTFS_OFS_BURST);

   // Default depth depends on the coding mode seen at reset release
   always @*
   begin
      case (i_coding_mode)
         `PTFS_MODE_10GR,
         `PTFS_MODE_XAUI,
         `PTFS_MODE_RXAUI: mode_depth = `PTFS_DEP_10G;
         `PTFS_MODE_40GR4: mode_depth = `PTFS_DEP_40G;
         default: mode_depth = `PTFS_DEP_OTHER;
      endcase
   end

   // Latched-high flags: a new event in the read cycle survives the clear
   always @*
   begin
      phase_d = rd_phase ? 3'h0 : phase_q;
      phase_d[2] = phase_d[2] | i_phx_empty | i_phx_full;
      phase_d[1] = phase_d[1] | i_phr_full;
      phase_d[0] = phase_d[0] | i_phr_empty;
      irq_flg_d = rd_flg ? 3'h0 : irq_flg_q;
      irq_flg_d[2] = irq_flg_d[2] | (i_crc_err & chk_en_q);
      irq_flg_d[1] = irq_flg_d[1] | i_rfifo_ovf;
      irq_flg_d[0] = irq_flg_d[0] | i_rfifo_udf;
   end

   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         phase_q <= 3'h0;
         irq_flg_q <= 3'h0;
      end
      else if (i_sw_rst)
      begin
         phase_q <= 3'h0;
         irq_flg_q <= 3'h0;
      end
      else
      begin
         phase_q <= phase_d;
         irq_flg_q <= irq_flg_d;
      end
   end

   // Control registers; soft reset keeps the "Retain" fields
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         irq_en_q <= 3'h0;
         depth_q <= `PTFS_DEP_OTHER;
         depth_loaded_q <= 1'b0;
         read_clr_q <= 1'b0;
         cnt_rst_q <= 1'b0;
         use_sfd_q <= 1'b0;
         gen_en_q <= 1'b0;
         chk_en_q <= 1'b0;
         pat_q <= `PTFS_PAT_NONE;
         crc_off_q <= 1'b0;
         seed_lo_q <= `PTFS_RST16;
         seed_hi_q <= `PTFS_RST16;
         burst_q <= `PTFS_RST16;
      end
      else if (i_sw_rst)
      begin
         depth_q <= mode_depth;
         depth_loaded_q <= 1'b1;
         cnt_rst_q <= 1'b0;
         use_sfd_q <= 1'b0;
         gen_en_q <= 1'b0;
         chk_en_q <= 1'b0;
      end
      else
      begin
         // Mode default is taken once; a later mode change needs soft reset
         if (!depth_loaded_q)
         begin
            depth_q <= mode_depth;
            depth_loaded_q <= 1'b1;
         end
         else if (wr_depth)
         begin
            depth_q <= i_wdata[`PTFS_F_DEP_HI:`PTFS_F_DEP_LO];
         end
         if (wr_irq_en)
         begin
            irq_en_q <= i_wdata[2:0];
         end
         // Counter reset holds one cycle only
         if (wr_ctrl_a)
         begin
            read_clr_q <= i_wdata[`PTFS_B_READ_CLR];
            cnt_rst_q <= i_wdata[`PTFS_B_CNT_RST];
            use_sfd_q <= i_wdata[`PTFS_B_USE_SFD];
            gen_en_q <= i_wdata[`PTFS_B_GEN_EN];
            chk_en_q <= i_wdata[`PTFS_B_CHK_EN];
         end
         else
         begin
            cnt_rst_q <= 1'b0;
         end
         if (wr_ctrl_b)
         begin
            pat_q <= i_wdata[`PTFS_F_PAT_HI:`PTFS_F_PAT_LO];
            crc_off_q <= i_wdata[`PTFS_B_CRC_OFF];
         end
         if (wr_seed_lo)
         begin
            seed_lo_q <= i_wdata;
         end
         if (wr_seed_hi)
         begin
            seed_hi_q <= i_wdata;
         end
         if (wr_burst)
         begin
            burst_q <= i_wdata;
         end
      end
   end

   // Reserved 11xx codes fall back to no mask rather than undefined data
   always @*
   begin
      if (pat_q[3:2] == `PTFS_PAT_RSVD_TOP)
      begin
         pat_eff = `PTFS_PAT_NONE;
      end
      else if (pat_q[3:1] == 3'h0)
      begin
         pat_eff = `PTFS_PAT_NONE;
      end
      else
      begin
         pat_eff = pat_q;
      end
   end

   // Interrupt is a plain OR of enabled sticky flags; no edge detect
   always @*
   begin
      irq_d = |(irq_flg_q & irq_en_q);
   end

   // Upper words snapshot on low-word read so a 48-bit read is atomic
   genvar gi;
   generate
      for (gi = 0; gi < N_CNT; gi = gi + 1)
      begin : g_cnt
         reg [CNT_W-17:0] snap_q;
         wire [15:0] base;
         wire [31:0] base_full;
         // Genvar arithmetic is 32 bits wide; keep the low address bits
         assign base_full = `PTFS_OFS_CNT_BASE + gi * `PTFS_CNT_STRIDE;
         assign base = base_full[15:0];
         assign lo_hit[gi] = (i_addr == base);
         assign mid_hit[gi] = (i_addr == base + `PTFS_CNT_MID);
         assign hi_hit[gi] = (i_addr == base + `PTFS_CNT_HI);
         assign lo_rd[gi] = i_rd && lo_hit[gi];
         assign snap_w[gi] = snap_q;
         always @(posedge i_clk_sys or posedge i_rst)
         begin
            if (i_rst)
            begin
               snap_q <= {(CNT_W-16){1'b0}};
            end
            // Soft reset empties snapshots; the counters themselves are not cleared
            else if (i_sw_rst)
            begin
               snap_q <= {(CNT_W-16){1'b0}};
            end
            else if (lo_rd[gi])
            begin
               snap_q <= i_cnt_vals[gi*CNT_W+16 +: CNT_W-16];
            end
         end
      end
   endgenerate

   // Read mux; unmapped and reserved bits return zero
   integer k;
   always @*
   begin
      rdata_d = 16'h0000;
      if (i_addr == `PTFS_OFS_PHASE)
      begin
         rdata_d = {13'h0000, phase_q};
      end
      else if (i_addr == `PTFS_OFS_IRQ_EN)
      begin
         rdata_d = {13'h0000, irq_en_q};
      end
      else if (i_addr == `PTFS_OFS_IRQ_FLG)
      begin
         rdata_d = {13'h0000, irq_flg_q};
      end
      else if (i_addr == `PTFS_OFS_DEPTH)
      begin
         rdata_d = {depth_q, 14'h0000};
      end
      else if (i_addr == `PTFS_OFS_CTRL_A)
      begin
         rdata_d[`PTFS_B_READ_CLR] = read_clr_q;
         rdata_d[`PTFS_B_CNT_RST] = cnt_rst_q;
         rdata_d[`PTFS_B_USE_SFD] = use_sfd_q;
         rdata_d[`PTFS_B_GEN_EN] = gen_en_q;
         rdata_d[`PTFS_B_CHK_EN] = chk_en_q;
      end
      else if (i_addr == `PTFS_OFS_CTRL_B)
      begin
         rdata_d = {8'h00, pat_q, crc_off_q, 3'h0};
      end
      else if (i_addr == `PTFS_OFS_SEED_LO)
      begin
         rdata_d = seed_lo_q;
      end
      else if (i_addr == `PTFS_OFS_SEED_HI)
      begin
         rdata_d = seed_hi_q;
      end
      else if (i_addr == `PTFS_OFS_BURST)
      begin
         rdata_d = burst_q;
      end
      else
      begin
         // Mid and high words come from the snapshot, never live
         for (k = 0; k < N_CNT; k = k + 1)
         begin
            if (lo_hit[k])
            begin
               rdata_d = i_cnt_vals[k*CNT_W +: 16];
            end
            if (mid_hit[k])
            begin
               rdata_d = snap_w[k][15:0];
            end
            if (hi_hit[k])
            begin
               rdata_d = snap_w[k][31:16];
            end
         end
      end
   end

   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rdata <= 16'h0000;
         o_irq <= 1'b0;
         o_rfifo_depth <= `PTFS_DEP_OTHER;
         o_read_clr_en <= 1'b0;
         o_cnt_clear <= 1'b0;
         o_cnt_rd_clr <= {N_CNT{1'b0}};
         o_chk_skip8 <= 1'b0;
         o_gen_en <= 1'b0;
         o_chk_en <= 1'b0;
         o_gen_run <= 1'b0;
         o_gen_continuous <= 1'b0;
         o_gen_count <= `PTFS_RST16;
         o_pattern <= `PTFS_PAT_NONE;
         o_crc_append <= 1'b1;
         o_seed <= 32'h00000000;
      end
      else
      begin
         o_rdata <= i_rd ? rdata_d : 16'h0000;
         o_irq <= irq_d;
         o_rfifo_depth <= depth_q;
         o_read_clr_en <= read_clr_q;
         o_cnt_clear <= cnt_rst_q;
         // Whole counter clears after its low word was read and snapshotted
         o_cnt_rd_clr <= read_clr_q ? lo_rd : {N_CNT{1'b0}};
         o_chk_skip8 <= use_sfd_q;
         o_gen_en <= gen_en_q;
         o_chk_en <= chk_en_q;
         o_gen_run <= gen_en_q && (burst_q != `PTFS_BURST_STOP);
         o_gen_continuous <= (burst_q == `PTFS_BURST_CONT);
         o_gen_count <= burst_q;
         o_pattern <= pat_eff;
         o_crc_append <= ~crc_off_q;
         o_seed <= {seed_hi_q, seed_lo_q};
      end
   end

endmodule // ptfs_regs

//--- ptfs_regs_checker.sv
// Port-level assertions for the test packet and FIFO status registers
`timescale 1ns/1ps
module ptfs_regs_checker #(
   parameter N_CNT = 5
)
(
   input wire i_clk_sys,
   input wire i_rst,
   input wire i_sw_rst,
   input wire [15:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [15:0] o_rdata,
   input wire i_phx_empty,
   input wire i_phx_full,
   input wire i_phr_full,
   input wire i_phr_empty,
   input wire i_rfifo_ovf,
   input wire o_cnt_clear,
   input wire [N_CNT-1:0] o_cnt_rd_clr,
   input wire o_gen_en,
   input wire o_gen_run,
   input wire o_gen_continuous,
   input wire [15:0] o_gen_count,
   input wire [3:0] o_pattern
);
   // Soft reset wipes flags, so every step must be outside it
   wire ok = !i_sw_rst;
   wire rd_ph = i_rd && i_addr == 16'hf008 && ok;
   wire ev_ph = i_phx_empty | i_phx_full | i_phr_full | i_phr_empty;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   tx_phase_flag_a: assert property (
      ((i_phx_empty | i_phx_full) && ok) ##1 (!i_rd && ok) ##1 rd_ph
      |=> o_rdata[2]) else $error("tx phase flag lost");
   rx_full_flag_a: assert property (
      (i_phr_full && ok) ##1 (!i_rd && ok) ##1 rd_ph
      |=> o_rdata[1]) else $error("rx full flag lost");
   rx_empty_flag_a: assert property (
      (i_phr_empty && ok) ##1 (!i_rd && ok) ##1 rd_ph
      |=> o_rdata[0]) else $error("rx empty flag lost");
   phase_read_clear_a: assert property (
      (rd_ph && !ev_ph) ##1 (!i_rd && ok && !ev_ph) ##1 (rd_ph && !ev_ph)
      |=> o_rdata[2:0] == 3'h0) else $error("phase flags not cleared");
   ovf_flag_a: assert property (
      (i_rfifo_ovf && ok) ##1 (!i_rd && ok) ##1
      (i_rd && i_addr == 16'hf00b && ok) |=> o_rdata[1])
      else $error("overflow flag lost");
   cnt_clear_pulse_a: assert property (
      (i_wr && i_addr == 16'hf010 && i_wdata[6] && ok) ##1 (!i_wr && ok)
      |=> o_cnt_clear ##1 !o_cnt_clear) else $error("counter clear pulse");
   rd_clear_src_a: assert property (
      o_cnt_rd_clr[2] |-> $past(i_rd) && $past(i_addr) == 16'hf021)
      else $error("read clear without low word read");
   gen_run_a: assert property (
      o_gen_run == (o_gen_en && o_gen_count != 16'h0000))
      else $error("generator run state");
   gen_cont_a: assert property (
      o_gen_continuous == (o_gen_count == 16'hffff))
      else $error("continuous state");
   pattern_legal_a: assert property (
      o_pattern != 4'h1 && o_pattern[3:2] != 2'h3)
      else $error("pattern not folded");
endmodule // ptfs_regs_checker
bind ptfs_regs ptfs_regs_checker #(.N_CNT(N_CNT)) u_chk (.i_clk_sys,
   .i_rst, .i_sw_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
   .i_phx_empty, .i_phx_full, .i_phr_full, .i_phr_empty, .i_rfifo_ovf,
   .o_cnt_clear, .o_cnt_rd_clr, .o_gen_en, .o_gen_run, .o_gen_continuous,
   .o_gen_count, .o_pattern);
